// ===== common/irq_sleep_pkg.sv
// Package with constants and types for the interrupt and sleep controller.
package irq_sleep_pkg;
  // Source indices; a lower index means a higher priority.
  localparam int SRC_RESET = 0;
  localparam int SRC_NMI = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_EXT2 = 3;
  localparam int SRC_EXT3 = 4;
  localparam int SRC_TIMER = 5;
  localparam int SRC_RX = 6;
  localparam int SRC_TX = 7;
  localparam int SRC_SOFT = 8;
  localparam int SRC_EXT4 = 9;
  localparam int NUM_SRC = 10;
  // Maskable sources sit in bits 0..7 of the mask and flag registers.
  localparam int NUM_MASKABLE = 8;
  localparam int MASK_EXT1 = 0;
  localparam int MASK_EXT2 = 1;
  localparam int MASK_EXT3 = 2;
  localparam int MASK_TIMER = 3;
  localparam int MASK_RX = 4;
  localparam int MASK_TX = 5;
  localparam int MASK_SOFT = 6;
  localparam int MASK_EXT4 = 7;
  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_MASK = 4'h0;
  localparam logic [3:0] ADDR_FLAG = 4'h1;
  localparam logic [3:0] ADDR_FLAG_SET = 4'h2;
  localparam logic [3:0] ADDR_FLAG_CLR = 4'h3;
  localparam logic [3:0] ADDR_PAGE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_EVT = 4'h6;
  localparam logic [3:0] ADDR_EVT_CLR = 4'h7;
  localparam logic [3:0] ADDR_EVT_EN = 4'h8;
  localparam logic [3:0] ADDR_GIE = 4'h9;
  // Reset values.
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [4:0] PAGE_RESET = 5'h00;
  // Vector geometry: two words per slot, 2K-word pages.
  localparam int VEC_SLOT_SHIFT = 1;
  localparam int PAGE_SHIFT = 11;
  // Deep sleep wake-up needs a pin active for this many machine cycles.
  localparam int WAKE_CYCLES = 5;
  // Depth of the return address stack.
  localparam int STACK_DEPTH = 8;
  // Number of shadowed CPU registers.
  localparam int NUM_SHADOW = 11;
  // Event bits of the interrupt status register.
  localparam int EVT_TAKEN = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_OVF = 2;
  localparam int NUM_EVT = 3;
  // Power states.
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_LIGHT = 4'b0010,
    ST_DEEP = 4'b0100,
    ST_HOLD = 4'b1000
  } power_e;
  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  // CPU control strobes.
  typedef struct packed {
    logic instr_done;
    logic call;
    logic ret_plain;
    logic ret_enable;
    logic light_sleep;
    logic deep_sleep;
    logic soft_irq;
  } cpu_ctl_s;
endpackage : irq_sleep_pkg

// ===== logic/dsp_interrupt_and_sleep_ctrl.sv
// Interrupt prioritiser, vector, stack, shadow and power-down control.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Accept four external lines, reset and NMI.
// - Raise serial, timer and software requests.
// - Fixed priority, reset first, line four last.
// - Maskable sources each have a mask bit.
// - Each maskable source has a pending flag.
// - Vectors sit on two-word boundaries.
// - Vector base relocates by 2K-word page pointer.
// - Interrupts wait for multicycle instruction end.
// - Eight-deep hardware stack holds return addresses.
// - Eleven registers shadowed on interrupt service.
// - Return-from-interrupt restores shadowed registers.
// - Bus-takeover low puts core in power-down.
// - Power-down halts the CPU; flags and registers keep updating.
// - Light sleep halts CPU, clock keeps running.
// - Any interrupt ends light sleep.
// - Deep sleep stops core and peripherals.
// - Deep sleep wake needs pin five cycles.
module dsp_interrupt_and_sleep_ctrl #(
  parameter int PC_W = 16,
  parameter int REG_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic nmi_n,
  input wire logic ext_request_1_n,
  input wire logic ext_request_2_n,
  input wire logic ext_request_3_n,
  input wire logic ext_request_4_n,
  input wire logic rx_serial_irq,
  input wire logic tx_serial_irq,
  input wire logic timer_irq,
  input wire logic [3:0] soft_numbered_irq,
  input wire logic hold_n,
  input wire irq_sleep_pkg::cpu_ctl_s cpu_ctl,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [irq_sleep_pkg::NUM_SHADOW-1:0][REG_W-1:0] cpu_regs,
  input wire irq_sleep_pkg::reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic take_irq,
  output logic [PC_W-1:0] vector_addr,
  output logic [PC_W-1:0] return_addr,
  output logic [irq_sleep_pkg::STACK_DEPTH-1:0] stack_level,
  output logic restore,
  output logic [irq_sleep_pkg::NUM_SHADOW-1:0][REG_W-1:0] shadow_regs,
  output logic cpu_halt,
  output logic periph_halt,
  output logic machine_clock_en,
  output logic irq_out
);
  import irq_sleep_pkg::*;

  // Active-high view of the external pins.
  wire logic [5:0] pin_act = {~ext_request_4_n, ~ext_request_3_n,
    ~ext_request_2_n, ~ext_request_1_n, ~nmi_n, ~reset_pin_n};

  // Registers.
  logic [NUM_MASKABLE-1:0] enable_mask_reg;
  logic [NUM_MASKABLE-1:0] pending_flag_reg;
  logic [4:0] vector_page_pointer;
  logic gie;
  logic nmi_pend;
  logic reset_pend;
  logic [NUM_EVT-1:0] evt_status;
  logic [NUM_EVT-1:0] evt_enable;
  power_e pstate;
  logic [2:0] wake_cnt;
  logic [3:0] sp;
  logic [STACK_DEPTH-1:0][PC_W-1:0] stack_mem;
  logic [3:0] soft_vec;
  logic [5:0] pin_prev;

  // Priority encoder used for the chosen source.
  function automatic logic [3:0] pick(input logic [NUM_SRC-1:0] req);
    logic [3:0] r;
    r = 4'hF;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : pick

  // Maskable sources in mask bit order mapped onto priority order.
  wire logic [NUM_MASKABLE-1:0] live = pending_flag_reg & enable_mask_reg;
  wire logic [NUM_SRC-1:0] req_vec = {live[MASK_EXT4], live[MASK_SOFT],
    live[MASK_TX], live[MASK_RX], live[MASK_TIMER], live[MASK_EXT3],
    live[MASK_EXT2], live[MASK_EXT1] & gie, nmi_pend, reset_pend};
  // Global enable gates every maskable source; reset and NMI bypass it.
  wire logic [NUM_SRC-1:0] gated = {req_vec[NUM_SRC-1:2] & {8{gie}},
    req_vec[1:0]};
  wire logic [3:0] winner = pick(gated);
  wire logic any_req = |gated;
  // Service only at an instruction boundary while the CPU runs.
  wire logic can_take = cpu_ctl.instr_done && (pstate == ST_RUN);
  wire logic take = any_req && can_take;
  wire logic [3:0] win_mask = winner - 4'd2;

  // Flag set sources from hardware and from software.
  wire logic sw_set = reg_req.wr && reg_req.addr == ADDR_FLAG_SET;
  wire logic sw_clr = reg_req.wr && reg_req.addr == ADDR_FLAG_CLR;
  // Rising edges of the general lines reach the flags through hw_set.
  wire logic [NUM_MASKABLE-1:0] hw_set = {pin_act[5] & ~pin_prev[5],
    cpu_ctl.soft_irq, tx_serial_irq, rx_serial_irq, timer_irq,
    pin_act[4] & ~pin_prev[4], pin_act[3] & ~pin_prev[3],
    pin_act[2] & ~pin_prev[2]};
  wire logic [NUM_MASKABLE-1:0] take_clr = (take && winner >= 4'd2) ?
    NUM_MASKABLE'(1) << win_mask[2:0] : '0;
  wire logic [NUM_MASKABLE-1:0] next_flag = ((pending_flag_reg
    & ~(sw_clr ? reg_req.wdata[7:0] : 8'h00) & ~take_clr)
    | (sw_set ? reg_req.wdata[7:0] : 8'h00)) | hw_set;

  // Vector address: page base plus two words per source slot.
  wire logic [PC_W-1:0] page_base = PC_W'(vector_page_pointer) << PAGE_SHIFT;
  wire logic [3:0] slot = (winner == SRC_SOFT) ? soft_vec : winner;
  wire logic [PC_W-1:0] next_vector = page_base
    | (PC_W'(slot) << VEC_SLOT_SHIFT);

  // Deep sleep wake needs any pin held for WAKE_CYCLES cycles.
  wire logic wake_deep = (pstate == ST_DEEP) && (|pin_act)
    && (wake_cnt == 3'(WAKE_CYCLES - 1));
  wire logic any_flag = |(pending_flag_reg | hw_set) || nmi_pend
    || reset_pend;
  wire logic push = take || (cpu_ctl.call && pstate == ST_RUN);
  wire logic pop = (cpu_ctl.ret_plain || cpu_ctl.ret_enable)
    && pstate == ST_RUN;
  wire logic ret_irq = pop && !cpu_ctl.call;
  wire logic [NUM_EVT-1:0] evt_set = {push && sp == 4'(STACK_DEPTH),
    wake_deep, take};
  wire logic evt_clr = reg_req.wr && reg_req.addr == ADDR_EVT_CLR;

  // Pin history for edge detection of the general lines.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_prev <= 6'h3F;
    else if (pstate != ST_DEEP)
      pin_prev <= pin_act;
  end

  // Pending flags; frozen in deep sleep, software set and clear included.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pending_flag_reg <= '0;
    else if (pstate != ST_DEEP)
      pending_flag_reg <= next_flag;
  end

  // Reset and NMI latches; set wins over the clear by service.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nmi_pend <= 1'b0;
      reset_pend <= 1'b0;
    end
    else
    begin
      nmi_pend <= (pin_act[1] & ~pin_prev[1])
        | (nmi_pend & ~(take && winner == SRC_NMI));
      reset_pend <= (pin_act[0] & ~pin_prev[0])
        | (reset_pend & ~(take && winner == SRC_RESET));
    end
  end

  // Software registers and global enable.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enable_mask_reg <= MASK_RESET[NUM_MASKABLE-1:0];
      vector_page_pointer <= PAGE_RESET;
      gie <= 1'b0;
      evt_enable <= '0;
      soft_vec <= 4'h0;
    end
    else
    begin
      if (reg_req.wr && reg_req.addr == ADDR_MASK)
        enable_mask_reg <= reg_req.wdata[7:0];
      if (reg_req.wr && reg_req.addr == ADDR_PAGE)
        vector_page_pointer <= reg_req.wdata[4:0];
      if (reg_req.wr && reg_req.addr == ADDR_EVT_EN)
        evt_enable <= reg_req.wdata[NUM_EVT-1:0];
      if (cpu_ctl.soft_irq)
        soft_vec <= soft_numbered_irq;
      // Service blocks maskables; enabling return or software reopens.
      if (take)
        gie <= 1'b0;
      else if (cpu_ctl.ret_enable && pstate == ST_RUN)
        gie <= 1'b1;
      else if (reg_req.wr && reg_req.addr == ADDR_GIE)
        gie <= reg_req.wdata[0];
    end
  end

  // Sticky event bits; a new event wins over a clear.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      evt_status <= '0;
    else
      evt_status <= (evt_status & ~(evt_clr ? reg_req.wdata[NUM_EVT-1:0]
        : '0)) | evt_set;
  end

  // Power state machine.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pstate <= ST_RUN;
      wake_cnt <= 3'h0;
    end
    else
    begin
      wake_cnt <= ((pstate == ST_DEEP) && (|pin_act) && !wake_deep) ?
        wake_cnt + 3'h1 : 3'h0;
      unique case (pstate)
        ST_RUN:
        begin
          if (!hold_n)
            pstate <= ST_HOLD;
          else if (cpu_ctl.deep_sleep)
            pstate <= ST_DEEP;
          else if (cpu_ctl.light_sleep)
            pstate <= ST_LIGHT;
        end
        ST_LIGHT:
        begin
          if (any_flag)
            pstate <= ST_RUN;
        end
        ST_DEEP:
        begin
          if (wake_deep)
            pstate <= ST_RUN;
        end
        ST_HOLD:
        begin
          if (hold_n)
            pstate <= ST_RUN;
        end
      endcase
    end
  end

  // Return address stack; saturates at eight entries.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sp <= 4'h0;
      stack_mem <= '0;
    end
    else if (push && sp < 4'(STACK_DEPTH))
    begin
      stack_mem[sp[2:0]] <= pc_in;
      sp <= sp + 4'h1;
    end
    else if (pop && !push && sp != 4'h0)
      sp <= sp - 4'h1;
  end

  // Shadow copies taken on service; restore strobe on return.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shadow_regs <= '0;
      restore <= 1'b0;
      take_irq <= 1'b0;
      vector_addr <= '0;
      return_addr <= '0;
    end
    else
    begin
      if (take)
        shadow_regs <= cpu_regs;
      restore <= ret_irq;
      take_irq <= take;
      if (take)
        vector_addr <= next_vector;
      if (pop && sp != 4'h0)
        return_addr <= stack_mem[3'(sp - 4'h1)];
    end
  end

  // Decoded outputs.
  assign cpu_halt = (pstate != ST_RUN);
  assign periph_halt = (pstate == ST_DEEP);
  assign machine_clock_en = (pstate != ST_DEEP);
  assign irq_out = |(evt_status & evt_enable);
  always_comb
  begin
    stack_level = '0;
    for (int i = 0; i < STACK_DEPTH; i++)
      stack_level[i] = (sp > 4'(i));
  end

  // Register read data, one cycle after the strobe.
  wire logic [15:0] rd_mux =
    reg_req.addr == ADDR_MASK ? {8'h00, enable_mask_reg} :
    reg_req.addr == ADDR_FLAG ? {8'h00, pending_flag_reg} :
    reg_req.addr == ADDR_PAGE ? {11'h000, vector_page_pointer} :
    reg_req.addr == ADDR_STATUS ? {8'h00, sp, pstate} :
    reg_req.addr == ADDR_EVT ? {13'h0000, evt_status} :
    reg_req.addr == ADDR_EVT_EN ? {13'h0000, evt_enable} :
    reg_req.addr == ADDR_GIE ? {15'h0000, gie} : 16'h0000;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_req.rd ? rd_mux : 16'h0000;
  end

  // Checks.
  property p_clear_on_take;
    @(posedge clk) disable iff (rst)
      take && winner >= 4'd2 && !hw_set[win_mask[2:0]]
      |=> !pending_flag_reg[$past(win_mask[2:0])];
  endproperty
  a_clear_on_take: assert property (p_clear_on_take)
    else $error("flag not cleared on service");
  property p_vec_align;
    @(posedge clk) disable iff (rst) take_irq |-> !vector_addr[0];
  endproperty
  a_vec_align: assert property (p_vec_align)
    else $error("vector not two-word aligned");
  property p_no_take_sleep;
    @(posedge clk) disable iff (rst) pstate != ST_RUN |-> !take;
  endproperty
  a_no_take_sleep: assert property (p_no_take_sleep)
    else $error("service while halted");
  property p_hold;
    @(posedge clk) disable iff (rst)
      pstate == ST_RUN && !hold_n |=> pstate == ST_HOLD;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold did not power down");
  sequence s_pins_held;
    (|pin_act && pstate == ST_DEEP) [*5];
  endsequence
  property p_deep_wake;
    @(posedge clk) disable iff (rst)
      pstate == ST_DEEP && wake_cnt == 3'h0 ##0 s_pins_held
      |=> pstate == ST_RUN;
  endproperty
  a_deep_wake: assert property (p_deep_wake)
    else $error("deep sleep wake not after five cycles");
  property p_stack_max;
    @(posedge clk) disable iff (rst) sp <= 4'(STACK_DEPTH);
  endproperty
  a_stack_max: assert property (p_stack_max)
    else $error("stack overflow");
  property p_shadow;
    @(posedge clk) disable iff (rst)
      take |=> shadow_regs == $past(cpu_regs);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow copy missed");
  property p_gie_block;
    @(posedge clk) disable iff (rst) take |=> !gie;
  endproperty
  a_gie_block: assert property (p_gie_block)
    else $error("maskables not blocked after service");
endmodule : dsp_interrupt_and_sleep_ctrl
`default_nettype wire

// ===== verif/ext_irq_devices.sv
// Model of the external devices that pull the interrupt request pins.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_devices (
  input wire logic [5:0] pull,
  output logic [5:0] line_n
);
  // Pins idle high through pull-ups; a device that pulls holds its pin low.
  // Bit 0 is the reset pin, bit 1 the non-maskable pin, bits 2..5 lines 1..4.
  assign line_n = ~pull;
endmodule : ext_irq_devices
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench for the interrupt and sleep controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_sleep_pkg::*;
  localparam cpu_ctl_s DONE = cpu_ctl_s'(7'h40);
  localparam cpu_ctl_s CALL = cpu_ctl_s'(7'h20);
  localparam cpu_ctl_s RET_PLAIN = cpu_ctl_s'(7'h10);
  localparam cpu_ctl_s RET_EN = cpu_ctl_s'(7'h08);
  localparam cpu_ctl_s LIGHT = cpu_ctl_s'(7'h04);
  localparam cpu_ctl_s DEEP = cpu_ctl_s'(7'h02);
  localparam cpu_ctl_s SOFT = cpu_ctl_s'(7'h01);
  logic clk, rst, hold_n, restore, take_irq, irq_out;
  logic cpu_halt, periph_halt, machine_clock_en;
  logic [5:0] pull;
  wire logic [5:0] line_n;
  logic [2:0] pls; // Timer, receive and transmit pulses.
  logic [3:0] softn;
  cpu_ctl_s ctl;
  reg_req_s req;
  logic [15:0] pc, reg_rdata, vector_addr, return_addr;
  logic [7:0] stack_level;
  logic [NUM_SHADOW-1:0][15:0] regs, shadow_regs;
  int mismatches, total_checks;
  int pin_slot[6] = '{SRC_RESET, SRC_NMI, SRC_EXT1, SRC_EXT2, SRC_EXT3,
    SRC_EXT4};
  int int_slot[4] = '{SRC_TIMER, SRC_RX, SRC_TX, 12};

  ext_irq_devices ext_u (.pull(pull), .line_n(line_n));
  dsp_interrupt_and_sleep_ctrl #(.PC_W(16), .REG_W(16)) dut_u (
    .clk(clk), .rst(rst), .reset_pin_n(line_n[0]), .nmi_n(line_n[1]),
    .ext_request_1_n(line_n[2]), .ext_request_2_n(line_n[3]),
    .ext_request_3_n(line_n[4]), .ext_request_4_n(line_n[5]),
    .rx_serial_irq(pls[1]), .tx_serial_irq(pls[2]), .timer_irq(pls[0]),
    .soft_numbered_irq(softn), .hold_n(hold_n), .cpu_ctl(ctl),
    .pc_in(pc), .cpu_regs(regs), .reg_req(req), .reg_rdata(reg_rdata),
    .take_irq(take_irq), .vector_addr(vector_addr),
    .return_addr(return_addr), .stack_level(stack_level),
    .restore(restore), .shadow_regs(shadow_regs), .cpu_halt(cpu_halt),
    .periph_halt(periph_halt), .machine_clock_en(machine_clock_en),
    .irq_out(irq_out));

  // The machine clock runs at 40 MHz.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares one value and counts the result.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Holds reset for five cycles.
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  // One-cycle register read; data is judged in the following cycle.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  // One-cycle control strobe; registered answers are visible on return.
  task automatic ctl_pulse(input cpu_ctl_s v);
    @(posedge clk);
    ctl <= v;
    @(posedge clk);
    ctl <= '0;
    #1;
  endtask : ctl_pulse

  // Raises an internal request: 0..2 peripheral pulses, 3 software.
  task automatic raise(input int i);
    if (i == 3)
      ctl_pulse(SOFT);
    else
    begin
      @(posedge clk);
      pls <= 3'(1 << i);
      @(posedge clk);
      pls <= 3'h0;
    end
    repeat (2) @(posedge clk);
  endtask : raise

  // Has an external device pull pin i low for n cycles.
  task automatic pin(input int i, input int n);
    @(posedge clk);
    pull[i] <= 1'b1;
    repeat (n) @(posedge clk);
    pull[i] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pin

  // Unmasks every maskable source and turns on global enable.
  task automatic enable_all();
    wr(ADDR_MASK, 16'h00FF);
    wr(ADDR_GIE, 16'h0001);
  endtask : enable_all

  // Reset values of registers and outputs.
  task automatic t_reset();
    do_reset();
    #1;
    check(16'(take_irq), 16'h0000);
    check(16'(machine_clock_en), 16'h0001);
    check(16'(cpu_halt), 16'h0000);
    rd(ADDR_MASK, MASK_RESET);
    rd(ADDR_PAGE, 16'(PAGE_RESET));
    rd(ADDR_FLAG, 16'h0000);
  endtask : t_reset

  // Internal sources are taken once, then blocked by the cleared enable.
  task automatic t_internal();
    for (int i = 0; i < 4; i++)
    begin
      do_reset();
      enable_all();
      raise(i);
      ctl_pulse(DONE);
      check(16'(take_irq), 16'h0001);
      check(vector_addr, 16'(int_slot[i] << VEC_SLOT_SHIFT));
      rd(ADDR_FLAG, 16'h0000);
      raise(i);
      ctl_pulse(DONE);
      check(16'(take_irq), 16'h0000);
    end
  endtask : t_internal

  // Pin requests vector into a relocated page.
  task automatic t_pins();
    for (int i = 0; i < 6; i++)
    begin
      do_reset();
      enable_all();
      wr(ADDR_PAGE, 16'(i + 1));
      pin(i, 2);
      ctl_pulse(DONE);
      check(16'(take_irq), 16'h0001);
      check(vector_addr, 16'((i + 1) << PAGE_SHIFT)
        | 16'(pin_slot[i] << VEC_SLOT_SHIFT));
    end
  endtask : t_pins

  // Priority, instruction boundary, flag access and masking.
  task automatic t_priority();
    do_reset();
    enable_all();
    wr(ADDR_FLAG_SET, 16'h0081);
    repeat (5)
    begin
      @(posedge clk);
      #1;
      check(16'(take_irq), 16'h0000);
    end
    ctl_pulse(DONE);
    check(vector_addr, 16'(SRC_EXT1 << VEC_SLOT_SHIFT));
    pin(1, 2);
    ctl_pulse(DONE);
    check(16'(take_irq), 16'h0001);
    check(vector_addr, 16'(SRC_NMI << VEC_SLOT_SHIFT));
    do_reset();
    wr(ADDR_GIE, 16'h0001);
    wr(ADDR_FLAG_SET, 16'h0001);
    rd(ADDR_FLAG, 16'h0001);
    ctl_pulse(DONE);
    check(16'(take_irq), 16'h0000);
    wr(ADDR_FLAG_CLR, 16'h0001);
    rd(ADDR_FLAG, 16'h0000);
  endtask : t_priority

  // Stack, shadow copy, restore, overflow event and interrupt output.
  task automatic t_stack();
    do_reset();
    enable_all();
    @(posedge clk);
    pc <= 16'h1234;
    for (int k = 0; k < NUM_SHADOW; k++)
      regs[k] <= 16'hA000 + 16'(k);
    raise(0);
    ctl_pulse(DONE);
    check(16'(stack_level), 16'h0001);
    for (int k = 0; k < NUM_SHADOW; k++)
      check(shadow_regs[k], 16'hA000 + 16'(k));
    rd(ADDR_EVT, 16'h0001);
    regs <= '0;
    ctl_pulse(RET_EN);
    check(16'(restore), 16'h0001);
    check(return_addr, 16'h1234);
    pc <= 16'h5678;
    ctl_pulse(CALL);
    ctl_pulse(RET_PLAIN);
    check(16'(restore), 16'h0001);
    check(16'(stack_level), 16'h0000);
    check(return_addr, 16'h5678);
    do_reset();
    repeat (8) ctl_pulse(CALL);
    check(16'(stack_level), 16'h00FF);
    ctl_pulse(CALL);
    rd(ADDR_EVT, 16'h0004);
    wr(ADDR_EVT_EN, 16'h0004);
    @(posedge clk);
    #1;
    check(16'(irq_out), 16'h0001);
    wr(ADDR_EVT_CLR, 16'h0004);
    @(posedge clk);
    #1;
    check(16'(irq_out), 16'h0000);
  endtask : t_stack

  // Bus takeover, light sleep and deep sleep.
  task automatic t_power();
    do_reset();
    enable_all();
    hold_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(16'(cpu_halt), 16'h0001);
    check(16'(periph_halt), 16'h0000);
    rd(ADDR_STATUS, 16'h0008);
    hold_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(16'(cpu_halt), 16'h0000);
    ctl_pulse(LIGHT);
    @(posedge clk);
    #1;
    check(16'(cpu_halt), 16'h0001);
    check(16'(machine_clock_en), 16'h0001);
    check(16'(periph_halt), 16'h0000);
    raise(0);
    #1;
    check(16'(cpu_halt), 16'h0000);
    ctl_pulse(DEEP);
    @(posedge clk);
    #1;
    check(16'(periph_halt), 16'h0001);
    check(16'(machine_clock_en), 16'h0000);
    pin(2, 4);
    #1;
    check(16'(cpu_halt), 16'h0001);
    pin(3, 6);
    #1;
    check(16'(cpu_halt), 16'h0000);
    rd(ADDR_EVT, 16'h0002);
    rd(ADDR_MASK, 16'h00FF);
  endtask : t_power

  // Watchdog against a hang.
  initial
  begin
    #400000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    hold_n = 1'b1;
    pull = 6'h00;
    pls = 3'h0;
    softn = 4'hC;
    ctl = '0;
    req = '0;
    pc = 16'h0000;
    regs = '0;
    mismatches = 0;
    total_checks = 0;
    t_reset();
    t_internal();
    t_pins();
    t_priority();
    t_stack();
    t_power();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
